// *** mode_regs_consts.svh ***
/*
 * Constants for the fieldbus slave mode control registers.
 * Assumes inclusion by its bare name from the top module and the testbench top.
 */
// Operation
// R1: Low config byte bit 7 freeze supported, bit 6 sync supported.
// R2: Early-ready bit clear: ready on data valid; set: one clock earlier.
// R3: Interrupt polarity bit: 0 active low output, 1 active high.
// R4: Station delay default select: 0 pure slave, 1 combined operation.
// R5: Watchdog tick 10 ms when bit clear, 1 ms when set.
// R6: Stop-bit check disable bit switches stop-bit monitoring off.
// R7: Start-bit check disable bit switches start-bit monitoring off.
// R8: Received parameter telegram overwrites both check disable bits.
// R9: High byte bit 15 reserved; bit 14 enables redundancy command.
// R10: Fail-safe clear bit accepts zero-length data exchange telegrams.
// R11: Special parameter buffer bit stores parameters directly there.
// R12: Extended parameter bit activates service access point 53.
// R13: User timer tick 1 ms when clear, 10 ms when set.
// R14: After acknowledge, interrupt inactive at least 1 us or 1 ms.
// R15: Slave protocol enable bit sets up all protocol access points.
// R16: Control register written at set and clear addresses by ones.
// R17: Watchdog reload bit loads user watchdog, then self-clears.
// R18: Configuration accepted swaps buffers only if swap enable set.
// R19: Leave-master request moves state machine to wait-parameters.
// R20: Go-offline finishes current request, enters offline, self-clears.
// R21: End-of-interrupt deasserts interrupt output and self-clears.
// R22: Controller start leaves offline, starts timers, clears go-offline.
// R23: Host writes config only offline, before starting controller.
// R24: Zero bits and reserved positions of control writes are ignored.
`ifndef MODE_REGS_CONSTS_SVH
`define MODE_REGS_CONSTS_SVH
`define OFS_CFG_LOW      8'h06
`define OFS_CFG_HIGH     8'h07
`define OFS_CTRL_SET     8'h08
`define OFS_CTRL_CLR     8'h09
`define OFS_STATUS       8'h0c
`define OFS_WD_VALUE     8'h10
`define CFG_RESET        16'h0100
`define CFG_WR_MASK      16'h7fff
`define CTRL_MASK        8'h3f
`define B_START          0
`define B_EOI            1
`define B_OFFL           2
`define B_LEAVE          3
`define B_SWAP           4
`define B_WDRL           5
`define B_EARLY          5
`define B_POL            4
`define B_STOPDIS        1
`define B_STARTDIS       0
`define B_EOI_BASE       9
`define CLK_MHZ          40
`define T_US_NS          1000
`define T_MS_NS          1000000
`define CYC_US           (`T_US_NS * `CLK_MHZ / 1000)
`define CYC_MS           (`T_MS_NS * `CLK_MHZ / 1000)
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// *** mode_regs_pkg.sv ***
/*
 * Types for the mode control registers.
 * Assumes the constants header is available.
 */
package mode_regs_pkg;
  typedef enum logic [1:0] {
    PS_OFFLINE  = 2'b00,
    PS_IDLE     = 2'b01,
    PS_DRAIN    = 2'b10
  } run_state_t;
  typedef struct packed {
    logic [1:0] st;
    logic       online;
  } status_t;
endpackage : mode_regs_pkg

// *** fieldbus_slave_mode_registers.sv ***
/*
 * Mode control register bank with AXI4-Lite slave.
 * Assumes protocol engine signals are synchronous to clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mode_regs_consts.svh"
module fieldbus_slave_mode_registers
  import mode_regs_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `CYC_MS
)(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  input  wire logic        irq_request,
  input  wire logic        prm_received,
  input  wire logic [1:0]  prm_check_bits,
  input  wire logic        cfg_okay_cmd,
  input  wire logic        request_busy,
  output logic             irq_out,
  output logic [15:0]      mode_config,
  output logic             buffer_swap,
  output logic             leave_master_request,
  output logic             timers_start,
  output logic             early_ready,
  output logic [15:0]      user_watchdog_counter,
  output logic             controller_online
);

  // ****************************************************
  // Bus write channel
  // ****************************************************
  function automatic logic sel(input logic [7:0] a, input logic [7:0] o);
    sel = (a[7:2] == o[7:2]) && (a[1:0] == o[1:0]);
  endfunction : sel

  logic [7:0]  awa_q, awa_d;
  logic        awh_q, awh_d;
  logic [31:0] wd_q, wd_d;
  logic        wh_q, wh_d;
  logic        bv_q, bv_d;
  logic [1:0]  br_q, br_d;
  logic        wr_fire;
  logic        wr_ok;

  // Byte offsets are not word aligned, so each offset is a word index
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[1:0] == 2'b00) && sel({2'b00, a[7:2]}, o);
  endfunction : hit

  assign wr_fire = awh_q && wh_q && !bv_q;
  assign wr_ok   = hit(awa_q, `OFS_CFG_LOW) || hit(awa_q, `OFS_CFG_HIGH)
                || hit(awa_q, `OFS_CTRL_SET) || hit(awa_q, `OFS_CTRL_CLR)
                || hit(awa_q, `OFS_WD_VALUE);

  always_comb
  begin
    awa_d = awa_q;
    awh_d = awh_q;
    wd_d  = wd_q;
    wh_d  = wh_q;
    bv_d  = bv_q;
    br_d  = br_q;
    if (s_awvalid && !awh_q)
    begin
      awa_d = s_awaddr;
      awh_d = 1'b1;
    end
    if (s_wvalid && !wh_q)
    begin
      wd_d = s_wstrb[0] ? s_wdata : 32'h0000_0000;
      wh_d = 1'b1;
    end
    if (wr_fire)
    begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bv_q && s_bready)
      bv_d = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      awa_q <= 8'h00;
      awh_q <= 1'b0;
      wd_q  <= 32'h0000_0000;
      wh_q  <= 1'b0;
      bv_q  <= 1'b0;
      br_q  <= 2'b00;
    end
    else
    begin
      awa_q <= awa_d;
      awh_q <= awh_d;
      wd_q  <= wd_d;
      wh_q  <= wh_d;
      bv_q  <= bv_d;
      br_q  <= br_d;
    end
  end

  // ****************************************************
  // Mode state
  // ****************************************************
  logic [15:0] cfg_q, cfg_d;
  logic [7:0]  ctl_q, ctl_d;
  logic [15:0] wdv_q, wdv_d;
  logic [15:0] wdc_q, wdc_d;
  run_state_t  st_q, st_d;
  logic        irq_q, irq_d;
  logic        swp_q, swp_d;
  logic        lvm_q, lvm_d;
  logic        tst_q, tst_d;
  logic [31:0] hold_q, hold_d;
  logic [7:0]  wb;
  logic        cw_lo, cw_hi, cw_set, cw_clr;

  assign wb     = wd_q[7:0];
  assign cw_lo  = wr_fire && hit(awa_q, `OFS_CFG_LOW);
  assign cw_hi  = wr_fire && hit(awa_q, `OFS_CFG_HIGH);
  assign cw_set = wr_fire && hit(awa_q, `OFS_CTRL_SET);
  assign cw_clr = wr_fire && hit(awa_q, `OFS_CTRL_CLR);

  always_comb
  begin
    cfg_d  = cfg_q;
    ctl_d  = ctl_q;
    wdv_d  = wdv_q;
    wdc_d  = wdc_q;
    st_d   = st_q;
    irq_d  = irq_q;
    swp_d  = 1'b0;
    lvm_d  = 1'b0;
    tst_d  = 1'b0;
    hold_d = (hold_q != 32'h0000_0000) ? hold_q - 32'h0000_0001 : hold_q;
    // Config writes only land while offline, as the host must ensure
    if (cw_lo && st_q == PS_OFFLINE)                    // [R1] [R23]
      cfg_d[7:0] = wb;
    if (cw_hi && st_q == PS_OFFLINE)                    // [R9]
      cfg_d[15:8] = wb & 8'(`CFG_WR_MASK >> 8);
    // In slave mode a parameter telegram rewrites the check disables
    if (prm_received && cfg_q[8])                       // [R8] [R15]
    begin
      cfg_d[`B_STOPDIS]  = prm_check_bits[1];          // [R6]
      cfg_d[`B_STARTDIS] = prm_check_bits[0];          // [R7]
    end
    if (wr_fire && hit(awa_q, `OFS_WD_VALUE))
      wdv_d = wd_q[15:0];
    if (cw_set)
      ctl_d = ctl_q | (wb & `CTRL_MASK);                // [R16] [R24]
    if (cw_clr)
      ctl_d = ctl_d & ~(wb & `CTRL_MASK);               // [R16] [R24]
    if (ctl_q[`B_WDRL])
    begin
      wdc_d = wdv_q;                                    // [R17]
      ctl_d[`B_WDRL] = 1'b0;                            // [R17]
    end
    else if (wdc_q != 16'h0000)
      wdc_d = wdc_q - 16'h0001;
    if (cfg_okay_cmd)
      swp_d = ctl_q[`B_SWAP];                           // [R18]
    if (ctl_q[`B_LEAVE])
    begin
      lvm_d = 1'b1;                                     // [R19]
      ctl_d[`B_LEAVE] = 1'b0;                           // [R19]
    end
    if (ctl_q[`B_EOI])
    begin
      irq_d = 1'b0;                                     // [R21]
      ctl_d[`B_EOI] = 1'b0;                             // [R21]
      hold_d = cfg_q[`B_EOI_BASE] ? MS_CYCLES           // [R14]
                                  : 32'(`CYC_US);       // [R14]
    end
    else if (irq_request && hold_q == 32'h0000_0000)
      irq_d = 1'b1;                                     // [R14]
    unique case (st_q)
      PS_OFFLINE:
        if (ctl_q[`B_START])
        begin
          st_d  = PS_IDLE;                              // [R22]
          tst_d = 1'b1;                                 // [R22]
          ctl_d[`B_OFFL]  = 1'b0;                       // [R22]
        end
      PS_IDLE:
        if (ctl_q[`B_OFFL])
          st_d = request_busy ? PS_DRAIN : PS_OFFLINE;  // [R20]
      PS_DRAIN:
        if (!request_busy)
          st_d = PS_OFFLINE;                            // [R20]
      default:
        st_d = PS_OFFLINE;
    endcase
    // Start stays set while online; dropped on entry so offline sticks
    if (st_q != PS_OFFLINE && st_d == PS_OFFLINE)
    begin
      ctl_d[`B_OFFL]  = 1'b0;                           // [R20]
      ctl_d[`B_START] = 1'b0;                           // [R20]
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_q  <= `CFG_RESET;                             // [R4] [R5] [R13]
      ctl_q  <= 8'h00;
      wdv_q  <= 16'h0000;
      wdc_q  <= 16'h0000;
      st_q   <= PS_OFFLINE;
      irq_q  <= 1'b0;
      swp_q  <= 1'b0;
      lvm_q  <= 1'b0;
      tst_q  <= 1'b0;
      hold_q <= 32'h0000_0000;
    end
    else
    begin
      cfg_q  <= cfg_d;
      ctl_q  <= ctl_d;
      wdv_q  <= wdv_d;
      wdc_q  <= wdc_d;
      st_q   <= st_d;
      irq_q  <= irq_d;
      swp_q  <= swp_d;
      lvm_q  <= lvm_d;
      tst_q  <= tst_d;
      hold_q <= hold_d;
    end
  end

  // ****************************************************
  // Read channel and outputs
  // ****************************************************
  logic        rv_q, rv_d;
  logic [31:0] rd_q, rd_d;
  logic [1:0]  rr_q, rr_d;
  logic        io_q, io_d;
  status_t     sts;

  assign sts.st     = st_q;
  assign sts.online = (st_q != PS_OFFLINE);
  // Output polarity follows the config bit, registered for a clean pin
  assign io_d = cfg_q[`B_POL] ? irq_d : ~irq_d;         // [R3]

  always_comb
  begin
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (s_arvalid && !rv_q)
    begin
      rv_d = 1'b1;
      rr_d = `RESP_OKAY;
      rd_d = 32'h0000_0000;
      if (hit(s_araddr, `OFS_CFG_LOW))
        rd_d[7:0] = cfg_q[7:0];
      else if (hit(s_araddr, `OFS_CFG_HIGH))
        rd_d[7:0] = cfg_q[15:8];
      else if (hit(s_araddr, `OFS_CTRL_SET) || hit(s_araddr, `OFS_CTRL_CLR))
        rd_d[7:0] = ctl_q;
      else if (hit(s_araddr, `OFS_STATUS))
        rd_d[2:0] = sts;
      else if (hit(s_araddr, `OFS_WD_VALUE))
        rd_d = {wdc_q, wdv_q};
      else
        rr_d = `RESP_SLVERR;
    end
    else if (rv_q && s_rready)
      rv_d = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= 2'b00;
      io_q <= 1'b1;
    end
    else
    begin
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
      io_q <= io_d;
    end
  end

  assign s_awready             = !awh_q;
  assign s_wready              = !wh_q;
  assign s_bvalid              = bv_q;
  assign s_bresp               = br_q;
  assign s_arready             = !rv_q;
  assign s_rvalid              = rv_q;
  assign s_rdata               = rd_q;
  assign s_rresp               = rr_q;
  assign irq_out               = io_q;
  assign mode_config           = cfg_q;                 // [R10] [R11] [R12]
  assign early_ready           = cfg_q[`B_EARLY];       // [R2]
  assign buffer_swap           = swp_q;
  assign leave_master_request  = lvm_q;
  assign timers_start          = tst_q;
  assign user_watchdog_counter = wdc_q;
  assign controller_online     = sts.online;

endmodule : fieldbus_slave_mode_registers
`default_nettype wire

// *** mode_regs_chk.sv ***
/* Checker for the mode register bank ports.
   Assumes binding onto the top module, one clock. */
`timescale 1ns/10ps
`default_nettype none
module mode_regs_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  input wire logic [31:0] s_rdata,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic        irq_request,
  input wire logic        irq_out,
  input wire logic [15:0] mode_config,
  input wire logic        early_ready,
  input wire logic        timers_start,
  input wire logic        controller_online,
  input wire logic        buffer_swap,
  input wire logic        cfg_okay_cmd,
  input wire logic        leave_master_request
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ****************
  // Port relations
  // ****************
  a_bresp_held: assert property (s_bvalid && !s_bready |=> s_bvalid
    && $stable(s_bresp)) else $error("write answer dropped");
  a_rdata_held: assert property (s_rvalid && !s_rready |=> s_rvalid
    && $stable(s_rdata)) else $error("read answer dropped");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  a_early_tie: assert property ($stable(mode_config)[*2] |->
    early_ready == mode_config[5]) else $error("early ready wrong");
  a_irq_idle: assert property ($stable(mode_config)
    && $past(irq_out) == !mode_config[4] && irq_out == mode_config[4]
    |-> $past(irq_request)) else $error("interrupt level wrong");
  a_start_online: assert property (timers_start |-> ##[0:1]
    controller_online) else $error("start without online");
  a_swap_cause: assert property (buffer_swap |-> $past(cfg_okay_cmd))
    else $error("swap without command");
  a_leave_once: assert property (leave_master_request |=>
    !leave_master_request) else $error("leave request stuck");
endmodule : mode_regs_chk
`default_nettype wire

// *** host_axi.sv ***
/* Host model: AXI4-Lite master with write and read tasks.
   Assumes one transfer of each kind at a time. */
`timescale 1ns/10ps
`default_nettype none
module host_axi (
  input wire logic        clk_sys,
  output var logic [7:0]  s_awaddr,
  output var logic        s_awvalid,
  output var logic [31:0] s_wdata,
  output var logic [3:0]  s_wstrb,
  output var logic        s_wvalid,
  output var logic        s_bready,
  output var logic [7:0]  s_araddr,
  output var logic        s_arvalid,
  output var logic        s_rready,
  input wire logic        s_awready,
  input wire logic        s_wready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0]  s_rresp,
  input wire logic        s_rvalid,
  input wire logic        s_arready
);
  initial {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready,
    s_araddr, s_arvalid, s_rready} = '0;
  // Writes only ones where a change is meant
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    s_awaddr <= a; s_wdata <= d; s_wstrb <= 4'hf;
    s_awvalid <= 1; s_wvalid <= 1; s_bready <= 1;
    while (!(aw && w))
    begin
      @(posedge clk_sys);
      if (s_awvalid && s_awready)
      begin
        aw = 1;
        s_awvalid <= 0;
      end
      if (s_wvalid && s_wready)
      begin
        w = 1;
        s_wvalid <= 0;
      end
    end
    do @(posedge clk_sys); while (!s_bvalid);
    r = s_bresp;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
    do @(posedge clk_sys); while (!s_arready);
    s_arvalid <= 0;
    while (!s_rvalid) @(posedge clk_sys);
    d = s_rdata;
    r = s_rresp;
  endtask : rd
endmodule : host_axi
`default_nettype wire

// *** fieldbus_slave_mode_registers_tb_top.sv ***
/* Testbench for the mode register bank.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "mode_regs_consts.svh"
module fieldbus_slave_mode_registers_tb_top;
  localparam logic [7:0] A_LO = `OFS_CFG_LOW << 2, A_HI = `OFS_CFG_HIGH << 2,
    A_S = `OFS_CTRL_SET << 2, A_C = `OFS_CTRL_CLR << 2, A_WD = `OFS_WD_VALUE << 2;
  logic clk_sys = 0, rstn = 0, irq_request = 0, prm_received = 0;
  logic cfg_okay_cmd = 0, request_busy = 0, swp = 0, lv = 0, ts = 0;
  logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awready;
  logic s_wready, s_bvalid, s_arready, s_rvalid, irq_out, buffer_swap;
  logic leave_master_request, timers_start, early_ready, controller_online;
  logic [1:0] prm_check_bits = 0, s_bresp, s_rresp, r;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0] s_wstrb;
  logic [15:0] mode_config, user_watchdog_counter;
  int num_errors = 0, tests_run = 0;
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (buffer_swap) swp <= 1;
    if (leave_master_request) lv <= 1;
    if (timers_start) ts <= 1;
  end
  fieldbus_slave_mode_registers #(.MS_CYCLES(100)) dut (.clk_sys, .rstn,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .irq_request,
    .prm_received, .prm_check_bits, .cfg_okay_cmd, .request_busy, .irq_out,
    .mode_config, .buffer_swap, .leave_master_request, .timers_start,
    .early_ready, .user_watchdog_counter, .controller_online);
  host_axi host (.clk_sys, .s_awaddr, .s_awvalid, .s_wdata, .s_wstrb,
    .s_wvalid, .s_bready, .s_araddr, .s_arvalid, .s_rready, .s_awready,
    .s_wready, .s_bresp, .s_bvalid, .s_rdata, .s_rresp, .s_rvalid,
    .s_arready);
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task rc(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, d, r);
    chk({24'h0, d[7:0]}, e);
  endtask : rc
  task w(input logic [7:0] a, input logic [31:0] v);
    host.wr(a, v, r);
  endtask : w
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task okay_cmd;
    swp <= 0;
    cfg_okay_cmd <= 1;
    cyc(1);
    cfg_okay_cmd <= 0;
    cyc(3);
  endtask : okay_cmd
  task end_sim;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // Run is about 150 cycles; generous margin
  initial
  begin
    cyc(20000);
    num_errors++;
    end_sim;
  end
  initial
  begin
    cyc(10);
    rstn <= 1;
    cyc(1);
    rc(A_LO, 0);
    rc(A_HI, 8'h01);
    w(A_LO, 8'he3);
    w(A_HI, 8'hfd);
    rc(A_HI, 8'h7d);
    chk(mode_config, 16'h7de3);
    chk(early_ready, 1);
    chk(irq_out, 1);
    host.rd(8'h04, d, r);
    chk(r, `RESP_SLVERR);
    prm_received <= 1;
    cyc(1);
    prm_received <= 0;
    cyc(2);
    rc(A_LO, 8'he0);
    w(A_WD, 32'h50);
    w(A_S, 1);
    cyc(3);
    chk(controller_online, 1);
    chk(ts, 1);
    w(A_LO, 0);
    rc(A_LO, 8'he0);
    irq_request <= 1;
    cyc(3);
    chk(irq_out, 0);
    w(A_S, 2);
    cyc(3);
    chk(irq_out, 1);
    cyc(30);
    chk(irq_out, 1);
    cyc(20);
    chk(irq_out, 0);
    rc(A_S, 1);
    irq_request <= 0;
    w(A_S, 8'h10);
    w(A_C, 0);
    rc(A_S, 8'h11);
    okay_cmd;
    chk(swp, 1);
    w(A_C, 8'h10);
    rc(A_C, 1);
    okay_cmd;
    chk(swp, 0);
    w(A_S, 8'h08);
    cyc(2);
    chk(lv, 1);
    rc(A_S, 1);
    w(A_S, 8'h20);
    cyc(2);
    chk(user_watchdog_counter, 16'h004f);
    rc(A_S, 1);
    request_busy <= 1;
    w(A_S, 8'h04);
    cyc(5);
    chk(controller_online, 1);
    request_busy <= 0;
    cyc(4);
    chk(controller_online, 0);
    end_sim;
  end
endmodule : fieldbus_slave_mode_registers_tb_top
bind fieldbus_slave_mode_registers mode_regs_chk u_chk (.clk_sys, .rstn,
  .s_bvalid, .s_bready, .s_bresp, .s_rvalid, .s_rready, .s_rdata, .s_arvalid,
  .s_arready, .irq_request, .irq_out, .mode_config, .early_ready,
  .timers_start, .controller_online, .buffer_swap, .cfg_okay_cmd,
  .leave_master_request);
`default_nettype wire
